// file: rtl/aes_engine.sv
// adc engine post-processing: offsets, scaling, angles, raw readout, brake compare
module aes_engine (
    // clock, reset, enable
    input wire logic clk,
    input wire logic arst_n,
    input wire logic ce,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // sample stream from the modulator filters
    input wire logic smp_valid,
    output logic smp_ready,
    input wire aes_pkg::aes_frame_t smp_data,
    // sensor angle input
    input wire logic [15:0] sensor_angle,
    input wire logic [15:0] mech_sensor_angle,
    input wire logic angle_dir_sub,
    // outputs to control core
    output logic [15:0] electrical_angle,
    output logic [15:0] mechanical_angle,
    output logic [15:0] phase_current_a,
    output logic [15:0] phase_current_b,
    output logic [15:0] phase_current_c_derived,
    output logic [15:0] analog_target,
    output logic analog_target_en,
    output logic brake_on,
    output logic result_valid
);
    // ------------------------------------------------------------
    // reset synchroniser
    // ------------------------------------------------------------
    logic rst_meta;
    logic rst_n;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [15:0] sat16(input logic signed [35:0] v);
        logic signed [35:0] s;
        s = v >>> aes_pkg::SCALE_SHIFT;
        if (s > 36'(aes_pkg::S16_MAX)) begin
            sat16 = aes_pkg::S16_MAX;
        end else if (s < 36'(aes_pkg::S16_MIN)) begin
            sat16 = aes_pkg::S16_MIN;
        end else begin
            sat16 = s[15:0];
        end
    endfunction

    function automatic logic [15:0] pick(input aes_pkg::aes_frame_t f, input logic [2:0] i);
        logic [15:0] w [aes_pkg::NUM_CH];
        w[0] = f.ch0;
        w[1] = f.ch1;
        w[2] = f.ch2;
        w[3] = f.ch3;
        w[4] = f.ch4;
        w[5] = f.ch5;
        w[6] = f.ch6;
        w[7] = f.ch7;
        pick = w[i];
    endfunction

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [31:0] cfg;
    logic [31:0] raw_adc_select;
    logic [15:0] angle_shift;
    logic [31:0] injected_sample_regs;
    logic [15:0] brake_on_thr;
    logic [15:0] brake_off_thr;
    logic [15:0] offs [aes_pkg::NUM_CH];
    logic [15:0] scl [aes_pkg::NUM_CH];
    logic wr_ok;
    assign wr_ok = ce && reg_wr;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg <= aes_pkg::CFG_RESET;
            raw_adc_select <= '0;
            angle_shift <= '0;
            injected_sample_regs <= '0;
            brake_on_thr <= '1;
            brake_off_thr <= '1;
        end else if (wr_ok) begin
            case (reg_addr)
                aes_pkg::ADDR_CFG: cfg <= reg_wdata;
                aes_pkg::ADDR_RAW_SELECT: raw_adc_select <= reg_wdata;
                aes_pkg::ADDR_ANGLE_SHIFT: angle_shift <= reg_wdata[15:0];
                aes_pkg::ADDR_INJ_AB: injected_sample_regs <= reg_wdata;
                aes_pkg::ADDR_BRAKE_THR: begin
                    brake_on_thr <= reg_wdata[aes_pkg::HI_LSB +: 16];
                    brake_off_thr <= reg_wdata[15:0];
                end
                default: ;
            endcase
        end
    end

    generate
        for (genvar g = 0; g < aes_pkg::NUM_CH; g++) begin : g_cal
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    offs[g] <= aes_pkg::OFFSET_RESET;
                    scl[g] <= aes_pkg::SCALE_RESET;
                end else if (wr_ok) begin
                    if (reg_addr == aes_pkg::ADDR_OFS_BASE + 8'(g)) begin
                        offs[g] <= reg_wdata[15:0];
                    end
                    if (reg_addr == aes_pkg::ADDR_SCL_BASE + 8'(g)) begin
                        scl[g] <= reg_wdata[15:0];
                    end
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // sample fifo and input mux
    // ------------------------------------------------------------
    aes_pkg::aes_state_t state;
    logic [aes_pkg::FIFO_WIDTH-1:0] fifo_q;
    logic fifo_valid;
    logic fifo_take;
    aes_pkg::aes_frame_t raw;
    aes_pkg::aes_frame_t use_f;

    aes_fifo #(.WIDTH(aes_pkg::FIFO_WIDTH), .DEPTH(aes_pkg::FIFO_DEPTH)) u_fifo (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .in_valid(smp_valid),
        .in_ready(smp_ready),
        .in_data(smp_data),
        .out_valid(fifo_valid),
        .out_ready(fifo_take),
        .out_data(fifo_q)
    );
    assign fifo_take = (state == aes_pkg::ST_IDLE);

    // single-ended channels: negative leg grounded, so midscale is zero input
    always_comb begin
        use_f = raw;
        if (cfg[aes_pkg::CFG_INJECT_BIT]) begin
            use_f.ch0 = injected_sample_regs[15:0];
            use_f.ch1 = injected_sample_regs[aes_pkg::HI_LSB +: 16];
        end
        if (cfg[aes_pkg::CFG_SE_CUR_BIT]) begin
            use_f.ch0 = use_f.ch0 | aes_pkg::SE_MID;
            use_f.ch1 = use_f.ch1 | aes_pkg::SE_MID;
        end
        if (cfg[aes_pkg::CFG_SE_ENC_BIT]) begin
            use_f.ch5 = use_f.ch5 | aes_pkg::SE_MID;
            use_f.ch6 = use_f.ch6 | aes_pkg::SE_MID;
            use_f.ch7 = use_f.ch7 | aes_pkg::SE_MID;
        end
    end

    // ------------------------------------------------------------
    // offset and scale pipeline
    // ------------------------------------------------------------
    logic signed [16:0] diff [aes_pkg::NUM_CH];
    logic signed [35:0] prod [aes_pkg::NUM_CH];
    logic [15:0] res [aes_pkg::NUM_CH];
    logic [15:0] cur_c;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= aes_pkg::ST_IDLE;
            raw <= '0;
        end else if (ce) begin
            case (state)
                aes_pkg::ST_IDLE: begin
                    if (fifo_valid) begin
                        raw <= fifo_q;
                        state <= aes_pkg::ST_OFFSET;
                    end
                end
                aes_pkg::ST_OFFSET: state <= aes_pkg::ST_SCALE;
                aes_pkg::ST_SCALE: state <= aes_pkg::ST_STORE;
                aes_pkg::ST_STORE: state <= aes_pkg::ST_IDLE;
                default: state <= aes_pkg::ST_IDLE;
            endcase
        end
    end

    generate
        for (genvar g = 0; g < aes_pkg::NUM_CH; g++) begin : g_scale
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    diff[g] <= '0;
                    prod[g] <= '0;
                    res[g] <= '0;
                end else if (ce) begin
                    if (state == aes_pkg::ST_OFFSET) begin
                        diff[g] <= $signed({1'b0, pick(use_f, 3'(g))})
                            - $signed({1'b0, offs[g]});
                    end
                    if (state == aes_pkg::ST_SCALE) begin
                        prod[g] <= 36'(diff[g] * $signed(scl[g]));
                    end
                    if (state == aes_pkg::ST_STORE) begin
                        res[g] <= sat16(prod[g]);
                    end
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // published results
    // ------------------------------------------------------------
    // taken from the product, so the derived phase matches the frame being published
    logic [15:0] cur_a_new;
    logic [15:0] cur_b_new;
    logic signed [17:0] c_sum;
    assign cur_a_new = sat16(prod[aes_pkg::CH_CUR_A]);
    assign cur_b_new = sat16(prod[aes_pkg::CH_CUR_B]);
    assign c_sum = -(18'(signed'(cur_a_new)) + 18'(signed'(cur_b_new)));
    always_comb begin
        if (c_sum > 18'(aes_pkg::S16_MAX)) begin
            cur_c = aes_pkg::S16_MAX;
        end else if (c_sum < 18'(aes_pkg::S16_MIN)) begin
            cur_c = aes_pkg::S16_MIN;
        end else begin
            cur_c = c_sum[15:0];
        end
    end

    logic pub;
    assign pub = ce && (state == aes_pkg::ST_STORE);
    logic [15:0] vm_raw;
    logic [15:0] gp_analog_first;
    logic [15:0] gp_analog_second;
    logic [15:0] enc_zero_channel;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            phase_current_a <= '0;
            phase_current_b <= '0;
            phase_current_c_derived <= '0;
            vm_raw <= '0;
            gp_analog_first <= '0;
            gp_analog_second <= '0;
            enc_zero_channel <= '0;
            result_valid <= 1'b0;
        end else if (ce) begin
            result_valid <= pub;
            if (pub) begin
                phase_current_a <= cur_a_new;
                phase_current_b <= cur_b_new;
                phase_current_c_derived <= cur_c;
                vm_raw <= use_f.ch2;
                gp_analog_first <= use_f.ch3;
                gp_analog_second <= use_f.ch4;
                enc_zero_channel <= sat16(prod[aes_pkg::CH_ENC_ZERO]);
            end
        end
    end
    assign analog_target = gp_analog_first;
    assign analog_target_en = cfg[aes_pkg::CFG_TARGET_BIT];

    // ------------------------------------------------------------
    // angles
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            electrical_angle <= '0;
            mechanical_angle <= '0;
        end else if (ce) begin
            // 16-bit wrap is the modulo 65536 turn
            if (angle_dir_sub) begin
                electrical_angle <= sensor_angle - angle_shift;
            end else begin
                electrical_angle <= sensor_angle + angle_shift;
            end
            mechanical_angle <= mech_sensor_angle;
        end
    end

    // ------------------------------------------------------------
    // brake chopper compare
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            brake_on <= 1'b0;
        end else if (ce) begin
            if (vm_raw > brake_on_thr) begin
                brake_on <= 1'b1;
            end else if (vm_raw < brake_off_thr) begin
                brake_on <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // read port
    // ------------------------------------------------------------
    logic [15:0] raw_vec [aes_pkg::NUM_CH];
    assign raw_vec[0] = use_f.ch0;
    assign raw_vec[1] = use_f.ch1;
    assign raw_vec[2] = vm_raw;
    assign raw_vec[3] = gp_analog_first;
    assign raw_vec[4] = gp_analog_second;
    assign raw_vec[5] = use_f.ch5;
    assign raw_vec[6] = use_f.ch6;
    assign raw_vec[7] = use_f.ch7;
    logic [2:0] sel_lo;
    logic [2:0] sel_hi;
    assign sel_lo = raw_adc_select[aes_pkg::SEL_LO_LSB +: 3];
    assign sel_hi = raw_adc_select[aes_pkg::SEL_HI_LSB +: 3];

    logic [31:0] next_rdata;
    always_comb begin
        next_rdata = '0;
        case (reg_addr)
            aes_pkg::ADDR_RAW_READOUT: next_rdata = {raw_vec[sel_hi], raw_vec[sel_lo]};
            aes_pkg::ADDR_RAW_SELECT: next_rdata = raw_adc_select;
            aes_pkg::ADDR_CFG: next_rdata = cfg;
            aes_pkg::ADDR_ANGLE_SHIFT: next_rdata = {16'h0000, angle_shift};
            aes_pkg::ADDR_ELEC_ANGLE: next_rdata = {16'h0000, electrical_angle};
            aes_pkg::ADDR_MECH_ANGLE: next_rdata = {16'h0000, mechanical_angle};
            aes_pkg::ADDR_INJ_AB: next_rdata = injected_sample_regs;
            aes_pkg::ADDR_BRAKE_THR: next_rdata = {brake_on_thr, brake_off_thr};
            aes_pkg::ADDR_CUR_AB: next_rdata = {phase_current_b, phase_current_a};
            aes_pkg::ADDR_CUR_C: next_rdata = {16'h0000, phase_current_c_derived};
            aes_pkg::ADDR_ENC_UX_VN: next_rdata = {enc_zero_channel, res[aes_pkg::CH_ENC_COS]};
            aes_pkg::ADDR_ENC_WY: next_rdata = {16'h0000, res[aes_pkg::CH_ENC_SIN]};
            aes_pkg::ADDR_STATUS: next_rdata = {30'h0000_0000, smp_ready, brake_on};
            default: begin
                if (reg_addr[7:3] == aes_pkg::ADDR_OFS_BASE[7:3]) begin
                    next_rdata = {16'h0000, offs[reg_addr[2:0]]};
                end else if (reg_addr[7:3] == aes_pkg::ADDR_SCL_BASE[7:3]) begin
                    next_rdata = {16'h0000, scl[reg_addr[2:0]]};
                end
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= '0;
        end else if (ce && reg_rd) begin
            reg_rdata <= next_rdata;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_angle_add;
        @(posedge clk) disable iff (!rst_n)
        (ce && !angle_dir_sub) |=> electrical_angle == 16'($past(sensor_angle) + $past(angle_shift));
    endproperty
    a_angle_add: assert property (p_angle_add) else $error("angle add wrong");

    property p_sym;
        @(posedge clk) disable iff (!rst_n)
        result_valid |-> phase_current_a != 16'h8000 && phase_current_c_derived != 16'h8000;
    endproperty
    a_sym: assert property (p_sym) else $error("asymmetric clip");

    property p_brake_hold;
        @(posedge clk) disable iff (!rst_n)
        (ce && brake_on && vm_raw >= brake_off_thr) |=> brake_on;
    endproperty
    a_brake_hold: assert property (p_brake_hold) else $error("brake dropped early");

    property p_brake_set;
        @(posedge clk) disable iff (!rst_n)
        (ce && vm_raw > brake_on_thr) |=> brake_on;
    endproperty
    a_brake_set: assert property (p_brake_set) else $error("brake not set");

    property p_brake_clear;
        @(posedge clk) disable iff (!rst_n)
        (ce && vm_raw < brake_off_thr && vm_raw <= brake_on_thr) |=> !brake_on;
    endproperty
    a_brake_clear: assert property (p_brake_clear) else $error("brake not cleared");

    property p_pipe;
        @(posedge clk) disable iff (!rst_n)
        (ce && state == aes_pkg::ST_IDLE && fifo_valid) ##1 ce[*3] |=> result_valid;
    endproperty
    a_pipe: assert property (p_pipe) else $error("result late");
endmodule

// file: rtl/aes_pkg.sv
// package: constants, types and register map of the adc scaling engine
package aes_pkg;
    // ------------------------------------------------------------
    // register map (word addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_RAW_READOUT = 8'h02;
    localparam logic [7:0] ADDR_RAW_SELECT = 8'h03;
    localparam logic [7:0] ADDR_CFG = 8'h10;
    localparam logic [7:0] ADDR_ANGLE_SHIFT = 8'h11;
    localparam logic [7:0] ADDR_ELEC_ANGLE = 8'h12;
    localparam logic [7:0] ADDR_MECH_ANGLE = 8'h13;
    localparam logic [7:0] ADDR_INJ_AB = 8'h14;
    localparam logic [7:0] ADDR_BRAKE_THR = 8'h15;
    localparam logic [7:0] ADDR_CUR_AB = 8'h16;
    localparam logic [7:0] ADDR_CUR_C = 8'h17;
    localparam logic [7:0] ADDR_ENC_UX_VN = 8'h18;
    localparam logic [7:0] ADDR_ENC_WY = 8'h19;
    localparam logic [7:0] ADDR_STATUS = 8'h1A;
    localparam logic [7:0] ADDR_OFS_BASE = 8'h20;
    localparam logic [7:0] ADDR_SCL_BASE = 8'h28;

    // ------------------------------------------------------------
    // channel numbering and field layout
    // ------------------------------------------------------------
    localparam int NUM_CH = 8;
    localparam int NUM_SCALED = 5;
    localparam int CH_CUR_A = 0;
    localparam int CH_CUR_B = 1;
    localparam int CH_SUPPLY = 2;
    localparam int CH_GP_FIRST = 3;
    localparam int CH_GP_SECOND = 4;
    localparam int CH_ENC_COS = 5;
    localparam int CH_ENC_ZERO = 6;
    localparam int CH_ENC_SIN = 7;
    localparam int SEL_LO_LSB = 0;
    localparam int SEL_HI_LSB = 8;
    localparam int CFG_INJECT_BIT = 0;
    localparam int CFG_SE_CUR_BIT = 1;
    localparam int CFG_SE_ENC_BIT = 2;
    localparam int CFG_TARGET_BIT = 3;
    localparam int HI_LSB = 16;
    localparam int SCALE_SHIFT = 8;
    localparam logic [31:0] CFG_RESET = 32'h0000_0000;
    localparam logic [15:0] SCALE_RESET = 16'h0100;
    localparam logic [15:0] OFFSET_RESET = 16'h8000;
    localparam logic [15:0] SE_MID = 16'h8000;
    localparam logic signed [15:0] S16_MAX = 16'sh7FFF;
    localparam logic signed [15:0] S16_MIN = -16'sh7FFF;

    localparam int FIFO_DEPTH = 32;
    localparam int FIFO_WIDTH = 128;

    typedef struct packed {
        logic [15:0] ch7;
        logic [15:0] ch6;
        logic [15:0] ch5;
        logic [15:0] ch4;
        logic [15:0] ch3;
        logic [15:0] ch2;
        logic [15:0] ch1;
        logic [15:0] ch0;
    } aes_frame_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } aes_bus_req_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_OFFSET = 2'b01,
        ST_SCALE = 2'b10,
        ST_STORE = 2'b11
    } aes_state_t;
endpackage

// file: rtl/aes_fifo.sv
// fifo with valid/ready on both sides
module aes_fifo #(
    parameter int WIDTH = 128,
    parameter int DEPTH = 32
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    logic do_wr;
    logic do_rd;

    assign in_ready = (cnt != (AW+1)'(DEPTH));
    assign out_valid = (cnt != '0);
    assign do_wr = ce && in_valid && in_ready;
    assign do_rd = ce && out_valid && out_ready;
    assign out_data = mem[rp];

    always_ff @(posedge clk) begin
        if (do_wr) begin
            mem[wp] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wp <= '0;
            rp <= '0;
            cnt <= '0;
        end else begin
            if (do_wr) begin
                wp <= wp + 1'b1;
            end
            if (do_rd) begin
                rp <= rp + 1'b1;
            end
            if (do_wr && !do_rd) begin
                cnt <= cnt + 1'b1;
            end else if (do_rd && !do_wr) begin
                cnt <= cnt - 1'b1;
            end
        end
    end
endmodule

// file: sim/test_aes_engine.sv
// register-driven testbench for the adc scaling engine
module test_aes_engine;
timeunit 1ns;
timeprecision 1ps;
`define check(got, exp) begin checked++; if ((got) !== (exp)) begin miscompares++; \
    $display("wrong value at %0t: got %h expected %h", $time, got, exp); end end
// ------------------------------------------------------------
// stimulus and design
// ------------------------------------------------------------
logic clk = 0, arst_n = 0, reg_wr = 0, reg_rd = 0, smp_valid = 0, dir_sub = 0, ce = 1;
logic [7:0] reg_addr = 8'h00;
logic [31:0] reg_wdata = 32'h0, reg_rdata, d;
logic smp_ready, tgt_en, brake_on, result_valid;
aes_pkg::aes_frame_t smp_data = '0;
logic [15:0] sens = 16'h0000, eang, cur_a, tgt;
int miscompares = 0, checked = 0, acc, refused;
aes_engine uut (.clk(clk), .arst_n(arst_n), .ce(ce), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .smp_valid(smp_valid), .smp_ready(smp_ready), .smp_data(smp_data),
    .sensor_angle(sens), .mech_sensor_angle(16'h1111), .angle_dir_sub(dir_sub),
    .electrical_angle(eang), .mechanical_angle(), .phase_current_a(cur_a),
    .phase_current_b(), .phase_current_c_derived(), .analog_target(tgt),
    .analog_target_en(tgt_en), .brake_on(brake_on), .result_valid(result_valid));
initial begin
    forever #20 clk = ~clk;
end
// ------------------------------------------------------------
// bus and frame tasks
// ------------------------------------------------------------
task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'b0;
endtask
task automatic rd(input logic [7:0] a);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
endtask
task automatic frame(input logic [15:0] a, b, vm);
    @(posedge clk);
    smp_valid <= 1'b1;
    smp_data <= {16'h8000, 16'h7FF0, 16'h8010, 16'h5678, 16'h1234, vm, b, a};
    #1 while (smp_ready !== 1'b1) begin @(posedge clk); #1; end
    @(posedge clk);
    smp_valid <= 1'b0;
    for (int i = 0; i < 30; i++) begin
        @(posedge clk);
        #1 if (result_valid === 1'b1) break;
    end
endtask
task automatic finish_test;
    $display("comparisons %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
endtask
initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    finish_test;
end
// ------------------------------------------------------------
// tests
// ------------------------------------------------------------
initial begin
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge clk);
    rd(8'h20); `check(d[15:0], 16'h8000)
    rd(8'h2F); `check(d[15:0], 16'h0100)
    rd(8'h15); `check(d, 32'hFFFFFFFF)
    rd(8'h7F); `check(d, 32'h0)
    $display("test reset values done");
    wr(8'h11, 32'h4000);
    sens <= 16'hD555;
    repeat (3) @(posedge clk);
    `check(eang, 16'h1555)
    dir_sub <= 1'b1;
    repeat (3) @(posedge clk);
    `check(eang, 16'h9555)
    rd(8'h12); `check(d[15:0], 16'h9555)
    rd(8'h13); `check(d[15:0], 16'h1111)
    // a write while the enable is low must be ignored
    @(posedge clk);
    ce <= 1'b0;
    wr(8'h11, 32'h1234);
    ce <= 1'b1;
    rd(8'h11); `check(d[15:0], 16'h4000)
    $display("test angle done");
    frame(16'h8300, 16'h7F00, 16'h9100);
    rd(8'h16); `check(d, 32'hFF000300)
    rd(8'h17); `check(d[15:0], 16'hFE00)
    rd(8'h18); `check(d, 32'hFFF00010)
    rd(8'h19); `check(d[15:0], 16'h0000)
    `check(brake_on, 1'b0)
    `check(tgt, 16'h1234)
    $display("test default scaling done");
    wr(8'h21, 32'h7000);
    wr(8'h03, 32'h0302);
    wr(8'h15, 32'h90007000);
    frame(16'h8300, 16'h7F00, 16'h9100);
    rd(8'h16); `check(d, 32'h0F000300)
    rd(8'h02); `check(d, 32'h12349100)
    `check(brake_on, 1'b1)
    frame(16'h8300, 16'h7F00, 16'h8000);
    `check(brake_on, 1'b1)
    rd(8'h02); `check(d[15:0], 16'h8000)
    frame(16'h8300, 16'h7F00, 16'h6000);
    rd(8'h1A); `check(d, 32'h2)
    `check(brake_on, 1'b0)
    $display("test offset, readout and brake done");
    wr(8'h10, 32'h9);
    wr(8'h14, 32'h80018400);
    frame(16'h8300, 16'h7F00, 16'h6000);
    rd(8'h16); `check(d, 32'h10010400)
    `check(tgt_en, 1'b1)
    wr(8'h10, 32'h6);
    frame(16'h0300, 16'h7F00, 16'h6000);
    rd(8'h16); `check(d, 32'h7FFF0300)
    rd(8'h18); `check(d, 32'h7FF00010)
    wr(8'h10, 32'h0);
    wr(8'h28, 32'hFF00);
    frame(16'h8300, 16'h7F00, 16'h6000);
    `check(cur_a, 16'hFD00)
    wr(8'h28, 32'h7FFF);
    frame(16'h0000, 16'h7F00, 16'h6000);
    `check(cur_a, 16'h8001)
    frame(16'hFFFF, 16'h7F00, 16'h6000);
    `check(cur_a, 16'h7FFF)
    $display("test scale sign and saturation done");
    acc = 0;
    refused = 0;
    @(posedge clk);
    smp_valid <= 1'b1;
    repeat (80) begin
        @(posedge clk);
        #1 if (smp_ready === 1'b1) acc++;
        else refused++;
    end
    smp_valid <= 1'b0;
    `check(refused > 0, 1'b1)
    `check(acc >= 32, 1'b1)
    repeat (400) @(posedge clk);
    `check(smp_ready, 1'b1)
    $display("test fifo fill and drain done");
    finish_test;
end
endmodule
